// file: common/glyph_render_defines.vh
/*
 Constants for the glyph render engine: control field positions,
 glyph sizes, byte counts, cell widths and heights, and state codes.
 Assumes plain Verilog-2005 and inclusion by bare name.
*/
`ifndef GLYPH_RENDER_DEFINES_VH
`define GLYPH_RENDER_DEFINES_VH

// Font control field positions
`define SIZE_HI        5
`define SIZE_LO        4
`define SET_HI         1
`define SET_LO         0

// Cell size selections
`define SIZE_SMALL     2'h0
`define SIZE_MEDIUM    2'h1
`define SIZE_LARGE     2'h2

// Character set selections
`define SET_LATIN1     2'h0
`define SET_LATIN2     2'h1
`define SET_LATIN4     2'h2
`define SET_CYRILLIC   2'h3

// Latin-1 extended range
`define EXT_FIRST      8'h80
`define EXT_LAST       8'h9F

// Full-width flag position in a user glyph code
`define WIDE_BIT       15

// Glyph byte counts per size
`define BYTES_8X16     8'h10
`define BYTES_16X16    8'h20
`define BYTES_12X24    8'h30
`define BYTES_24X24    8'h48
`define BYTES_16X32    8'h40
`define BYTES_32X32    8'h80

// Cell widths and heights
`define W8             6'h08
`define W12            6'h0C
`define W16            6'h10
`define W24            6'h18
`define W32            6'h20
`define H16            6'h10
`define H24            6'h18
`define H32            6'h20

// Ignored nibble of odd bytes in 12-wide rows
`define LOW_NIBBLE     8'h0F

// Engine states
`define ST_IDLE        3'h0
`define ST_FETCH       3'h1
`define ST_WAIT        3'h2
`define ST_PAINT       3'h3

`endif

// file: src/glyph_addr_calc.v
/*
 Maps a user glyph code and cell size to the absolute bitmap address,
 byte count, cell width and cell height.
 Assumes the base address is stable while the engine works.
*/
`timescale 1ns/1ps
`include "glyph_render_defines.vh"

module glyph_addr_calc #(
  parameter ADDR_W = 32               // Display memory address width
) (
  // Request
  input  wire [15:0]       glyphCode,  // Code written by the host
  input  wire [1:0]        cellSize,   // Size selection
  input  wire [ADDR_W-1:0] baseAddr,   // User glyph region base
  // Result
  output reg  [ADDR_W-1:0] glyphAddr,  // Absolute bitmap address
  output reg  [7:0]        byteCount,  // Bytes in the bitmap
  output reg  [5:0]        cellWidth,  // Pixels per row
  output reg  [5:0]        cellHeight  // Rows
);

  wire wide = glyphCode[`WIDE_BIT];  // Full-width code range

  // Size lookup from width class and cell size
  always @* begin
    case (cellSize)
      `SIZE_MEDIUM: begin
        byteCount  = wide ? `BYTES_24X24 : `BYTES_12X24;
        cellWidth  = wide ? `W24 : `W12;
        cellHeight = `H24;
      end
      `SIZE_LARGE: begin
        byteCount  = wide ? `BYTES_32X32 : `BYTES_16X32;
        cellWidth  = wide ? `W32 : `W16;
        cellHeight = `H32;
      end
      default: begin
        byteCount  = wide ? `BYTES_16X16 : `BYTES_8X16;
        cellWidth  = wide ? `W16 : `W8;
        cellHeight = `H16;
      end
    endcase
    glyphAddr = baseAddr + {{(ADDR_W-16){1'b0}}, glyphCode} * {{(ADDR_W-8){1'b0}}, byteCount};
  end

endmodule // glyph_addr_calc

// file: src/text_glyph_render.v
/*
 Character rendering engine: takes a character code from the host,
 fetches the glyph bitmap from the built-in font store or from the
 user glyph region, and writes expanded pixels in foreground or
 background colour to the display buffer.
 Assumes font store and memory read ports of any latency with a
 valid strobe, and a pixel sink with a ready handshake.
*/
`timescale 1ns/1ps
`include "glyph_render_defines.vh"

// Operation
// - Built-in sizes chosen by control bits 5:4
// - Character set chosen by control bits 1:0
// - Colours come from foreground, background registers
// - One code write renders whole glyph
// - Latin-1 codes 80h-9Fh render extension glyphs
// - User codes below 8000h are half width
// - User codes 8000h and above are full width
// - User code converted to absolute address
// - 8x16 glyph at base plus code*16
// - 16x16 glyph at base plus code*32
// - 12x24 glyph at base plus code*48
// - Odd bytes drop low nibble for 12-wide
// - 24x24 glyph at base plus code*72
// - 16x32 glyph at base plus code*64
// - 32x32 glyph at base plus code*128
module text_glyph_render #(
  parameter ADDR_W  = 32,  // Memory address width
  parameter COLOR_W = 24   // Pixel colour width
) (
  // Clock and reset
  input  wire               ref_clk,       // Core clock
  input  wire               sys_rst,       // Synchronous reset, high
  // Configuration
  input  wire [7:0]         fontControl,   // Size and set fields
  input  wire               userSource,    // 1 selects user glyph region
  input  wire [ADDR_W-1:0]  user_glyph_base_address, // Region base
  input  wire [7:0]         fgColor0,      // Foreground byte 0
  input  wire [7:0]         fgColor1,      // Foreground byte 1
  input  wire [7:0]         fgColor2,      // Foreground byte 2
  input  wire [7:0]         bgColor0,      // Background byte 0
  input  wire [7:0]         bgColor1,      // Background byte 1
  input  wire [7:0]         bgColor2,      // Background byte 2
  // Host code write
  input  wire               codeValid,     // Code write strobe
  input  wire [15:0]        user_glyph_code, // Character or glyph code
  output wire               codeReady,     // Engine idle
  output reg                busy,          // Rendering in progress
  // Built-in font store read
  output reg                romRead,       // Read strobe
  output reg  [1:0]         romSet,        // Selected character set
  output reg  [1:0]         romSize,       // Selected cell size
  output reg                romExtended,   // Latin-1 extension glyph
  output reg  [7:0]         romCode,       // Character code
  output reg  [7:0]         romByte,       // Byte index in glyph
  input  wire               romValid,      // Data valid
  input  wire [7:0]         romData,       // Glyph byte
  // User glyph region read
  output reg                memRead,       // Read strobe
  output reg  [ADDR_W-1:0]  user_glyph_address, // Byte address
  input  wire               memValid,      // Data valid
  input  wire [7:0]         memData,       // Glyph byte
  // Pixel output
  output reg                pixValid,      // Pixel strobe
  output reg  [5:0]         pixX,          // Column in cell
  output reg  [5:0]         pixY,          // Row in cell
  output reg  [COLOR_W-1:0] pixColor,      // Pixel colour
  input  wire               pixReady,      // Sink accepts pixel
  output reg                glyphDone      // Pulse at end of glyph
);

  ////////////////////////////////////////////////////////////////////////
  // Address and geometry

  wire [ADDR_W-1:0] calcAddr;    // Bitmap start in user region
  wire [7:0]        calcBytes;   // Bitmap length
  wire [5:0]        calcWidth;   // Cell width
  wire [5:0]        calcHeight;  // Cell height

  glyph_addr_calc #(.ADDR_W(ADDR_W)) addrCalc (
    .glyphCode  (user_glyph_code),
    .cellSize   (fontControl[`SIZE_HI:`SIZE_LO]),
    .baseAddr   (user_glyph_base_address),
    .glyphAddr  (calcAddr),
    .byteCount  (calcBytes),
    .cellWidth  (calcWidth),
    .cellHeight (calcHeight)
  );

  ////////////////////////////////////////////////////////////////////////
  // Engine state

  reg [2:0]        state;      // Engine state
  reg              fromUser;   // Latched source
  reg              narrow12;   // 12-wide cell in use
  reg [7:0]        byteIdx;    // Current byte in glyph
  reg [7:0]        byteTotal;  // Bytes in glyph
  reg [5:0]        width;      // Cell width latched
  reg [ADDR_W-1:0] baseLatch;  // Bitmap start latched
  reg [7:0]        shiftByte;  // Byte being painted
  reg [3:0]        bitsLeft;   // Bits left in byte
  reg [5:0]        col;        // Current column
  reg [5:0]        row;        // Current row

  assign codeReady = (state == `ST_IDLE);

  // Significant bits in a byte, odd bytes of 12-wide rows hold four
  function [3:0] sigBits;
    input       is12;
    input [7:0] idx;
    begin
      sigBits = (is12 && idx[0]) ? 4'h4 : 4'h8;
    end
  endfunction

  wire       dataValid = fromUser ? memValid : romValid;  // Source strobe
  wire [7:0] dataRaw   = fromUser ? memData : romData;    // Source byte
  // low nibble masked on odd bytes of 12-wide rows
  wire [7:0] dataByte  = (narrow12 && byteIdx[0]) ? (dataRaw & ~`LOW_NIBBLE) : dataRaw;

  wire [COLOR_W-1:0] fgColor = {fgColor2, fgColor1, fgColor0};
  wire [COLOR_W-1:0] bgColor = {bgColor2, bgColor1, bgColor0};

  ////////////////////////////////////////////////////////////////////////
  // Fetch and paint sequence

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= `ST_IDLE;
      busy <= 1'b0;
      fromUser <= 1'b0;
      narrow12 <= 1'b0;
      byteIdx <= 8'h00;
      byteTotal <= 8'h00;
      width <= 6'h00;
      baseLatch <= {ADDR_W{1'b0}};
      shiftByte <= 8'h00;
      bitsLeft <= 4'h0;
      col <= 6'h00;
      row <= 6'h00;
      romRead <= 1'b0;
      romSet <= 2'h0;
      romSize <= 2'h0;
      romExtended <= 1'b0;
      romCode <= 8'h00;
      romByte <= 8'h00;
      memRead <= 1'b0;
      user_glyph_address <= {ADDR_W{1'b0}};
      pixValid <= 1'b0;
      pixX <= 6'h00;
      pixY <= 6'h00;
      pixColor <= {COLOR_W{1'b0}};
      glyphDone <= 1'b0;
    end else begin
      romRead <= 1'b0;
      memRead <= 1'b0;
      glyphDone <= 1'b0;
      case (state)
        `ST_IDLE: begin
          if (codeValid) begin
            busy <= 1'b1;
            fromUser <= userSource;
            byteIdx <= 8'h00;
            col <= 6'h00;
            row <= 6'h00;
            if (userSource) begin
              byteTotal <= calcBytes;
              width <= calcWidth;
              narrow12 <= (calcWidth == `W12);
              baseLatch <= calcAddr;
            end else begin
              romSize <= fontControl[`SIZE_HI:`SIZE_LO];
              romSet <= fontControl[`SET_HI:`SET_LO];
              romCode <= user_glyph_code[7:0];
              romExtended <= (fontControl[`SET_HI:`SET_LO] == `SET_LATIN1) &&
                             (user_glyph_code[7:0] >= `EXT_FIRST) &&
                             (user_glyph_code[7:0] <= `EXT_LAST);
              byteTotal <= (fontControl[`SIZE_HI:`SIZE_LO] == `SIZE_MEDIUM) ?
                           `BYTES_12X24 : (fontControl[`SIZE_HI:`SIZE_LO] ==
                           `SIZE_LARGE) ? `BYTES_16X32 : `BYTES_8X16;
              width <= (fontControl[`SIZE_HI:`SIZE_LO] == `SIZE_MEDIUM) ? `W12 :
                       (fontControl[`SIZE_HI:`SIZE_LO] == `SIZE_LARGE) ? `W16 : `W8;
              narrow12 <= (fontControl[`SIZE_HI:`SIZE_LO] == `SIZE_MEDIUM);
            end
            state <= `ST_FETCH;
          end
        end
        `ST_FETCH: begin
          if (fromUser) begin
            memRead <= 1'b1;
            user_glyph_address <= baseLatch + {{(ADDR_W-8){1'b0}}, byteIdx};
          end else begin
            romRead <= 1'b1;
            romByte <= byteIdx;
          end
          state <= `ST_WAIT;
        end
        `ST_WAIT: begin
          // Byte arrives from the selected source
          if (dataValid) begin
            shiftByte <= dataByte;
            bitsLeft <= sigBits(narrow12, byteIdx);
            state <= `ST_PAINT;
          end
        end
        `ST_PAINT: begin
          // Hold pixel until the sink takes it
          if (!pixValid || pixReady) begin
            if (bitsLeft != 4'h0) begin
              pixValid <= 1'b1;
              pixX <= col;
              pixY <= row;
              pixColor <= shiftByte[7] ? fgColor : bgColor;
              shiftByte <= {shiftByte[6:0], 1'b0};
              bitsLeft <= bitsLeft - 4'h1;
              if (col == width - 6'h01) begin
                col <= 6'h00;
                row <= row + 6'h01;
              end else begin
                col <= col + 6'h01;
              end
            end else begin
              pixValid <= 1'b0;
              if (byteIdx == byteTotal - 8'h01) begin
                busy <= 1'b0;
                glyphDone <= 1'b1;
                state <= `ST_IDLE;
              end else begin
                byteIdx <= byteIdx + 8'h01;
                state <= `ST_FETCH;
              end
            end
          end
        end
        default: state <= `ST_IDLE;
      endcase
    end
  end

endmodule // text_glyph_render

// file: tb/text_glyph_render_sva.sv
/*
 Port checker for the glyph render engine.
 Assumes a bind onto text_glyph_render with one clock domain.
*/
`timescale 1ns/1ps
module text_glyph_render_sva #(
  parameter COLOR_W = 24                                  // Pixel colour width
) (
  // Clock and reset
  input wire               ref_clk,
  input wire               sys_rst,
  // Configuration
  input wire [7:0]         fontControl,
  input wire [7:0]         fgColor0,                      // Foreground byte 0
  input wire [7:0]         fgColor1,                      // Foreground byte 1
  input wire [7:0]         fgColor2,                      // Foreground byte 2
  input wire [7:0]         bgColor0,                      // Background byte 0
  input wire [7:0]         bgColor1,                      // Background byte 1
  input wire [7:0]         bgColor2,                      // Background byte 2
  // Code port
  input wire               codeValid,
  input wire               codeReady,
  input wire               busy,
  input wire               glyphDone,
  // Read ports
  input wire               romRead,
  input wire [1:0]         romSet,
  input wire [1:0]         romSize,
  input wire               romExtended,
  input wire [7:0]         romCode,
  input wire               memRead,
  // Pixel port
  input wire               pixValid,
  input wire [5:0]         pixX,
  input wire [5:0]         pixY,
  input wire [COLOR_W-1:0] pixColor,
  input wire               pixReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Colours as the engine must paint them
  wire [COLOR_W-1:0] fg = {fgColor2, fgColor1, fgColor0};
  wire [COLOR_W-1:0] bg = {bgColor2, bgColor1, bgColor0};
  wire               hiCode = romCode >= 8'h80 && romCode <= 8'h9F;

  property p_take; codeValid && codeReady |=> busy && !codeReady; endproperty
  a_take: assert property (p_take) else $error("code not taken");
  property p_done; glyphDone |-> codeReady ##1 !glyphDone; endproperty
  a_done: assert property (p_done) else $error("end pulse wrong");
  property p_hold;
    pixValid && !pixReady |=> pixValid && $stable(pixColor) && $stable({pixX, pixY});
  endproperty
  a_hold: assert property (p_hold) else $error("pixel moved while stalled");
  property p_colour; pixValid |-> pixColor == fg || pixColor == bg; endproperty
  a_colour: assert property (p_colour) else $error("pixel colour foreign");
  property p_ext; romRead && romSet == 2'h0 && hiCode |-> romExtended; endproperty
  a_ext: assert property (p_ext) else $error("extension glyph missed");
  property p_noext; romRead && (romSet != 2'h0 || !hiCode) |-> !romExtended; endproperty
  a_noext: assert property (p_noext) else $error("extension glyph wrong");
  property p_size; romRead |-> romSize == fontControl[5:4]; endproperty
  a_size: assert property (p_size) else $error("cell size wrong");
  property p_set; romRead |-> romSet == fontControl[1:0]; endproperty
  a_set: assert property (p_set) else $error("character set wrong");
  property p_gap; memRead |=> !memRead [*4]; endproperty
  a_gap: assert property (p_gap) else $error("fetches too close");
endmodule // text_glyph_render_sva

bind text_glyph_render text_glyph_render_sva #(.COLOR_W(COLOR_W)) chk (.*);

// file: tb/glyph_mem_model.sv
/*
 Font store and glyph memory model: answers each read after lag cycles.
 Assumes lag is at least 1; data is scrambled outside the valid cycle.
*/
`timescale 1ns/1ps
module glyph_mem_model (
  // Clock and latency
  input  wire        ref_clk,
  input  wire [3:0]  lag,
  // Requests
  input  wire        romRead,
  input  wire [7:0]  romCode,
  input  wire [7:0]  romByte,
  input  wire        memRead,
  input  wire [31:0] user_glyph_address,
  // Answers
  output reg         romValid = 1'b0,
  output reg  [7:0]  romData  = 8'h00,
  output reg         memValid = 1'b0,
  output reg  [7:0]  memData  = 8'h00
);
  reg [3:0] cnt   = 4'h0;  // Cycles to answer
  reg       isRom = 1'b0;  // Pending source
  reg [7:0] val   = 8'h00; // Pending byte
  ////////////////////////////////////////////////////////////////////////
  // Data inverts every idle cycle so stale bytes never look valid
  always @(posedge ref_clk) begin
    romValid <= 1'b0;
    memValid <= 1'b0;
    romData  <= ~romData;
    memData  <= ~memData;
    if (romRead || memRead) begin
      cnt   <= lag;
      isRom <= romRead;
      val   <= romRead ? (romCode ^ romByte ^ 8'h5A) :
               (user_glyph_address[7:0] ^ user_glyph_address[15:8] ^ 8'hC3);
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        romValid <= isRom;
        memValid <= !isRom;
        if (isRom) romData <= val;
        else memData <= val;
      end
    end
  end
endmodule // glyph_mem_model

// file: tb/testbench.sv
/*
 Self-checking bench for the glyph render engine.
 Assumes the memory model above and a stalling pixel sink.
*/
`timescale 1ns/1ps
module testbench;
  reg         ref_clk = 1'b0, sys_rst = 1'b1, userSource = 1'b0, codeValid = 1'b0;
  reg  [7:0]  fontControl = 8'h00;
  reg  [15:0] user_glyph_code = 16'h0000;
  reg         pixReady = 1'b1, stall = 1'b0;
  reg  [3:0]  lag = 4'h1;
  wire        codeReady, busy, romRead, romExtended, romValid, memRead, memValid;
  wire        pixValid, glyphDone;
  wire [1:0]  romSet, romSize;
  wire [7:0]  romCode, romByte, romData, memData;
  wire [31:0] user_glyph_address;
  wire [5:0]  pixX, pixY;
  wire [23:0] pixColor;
  integer     err_count = 0, check_count = 0, nRead = 0, nPix = 0;
  reg  [31:0] firstAddr = 32'h0, prevAddr = 32'h0;
  reg  [7:0]  curByte = 8'h00;  // Byte being painted
  reg  [23:0] fg = 24'h112233;  // Foreground as the host set it
  reg  [23:0] bg = 24'hAABBCC;  // Background as the host set it

  always #2 ref_clk = ~ref_clk;
  // Sink stalls every other cycle on alternate glyphs
  always @(negedge ref_clk) pixReady <= stall ? ~pixReady : 1'b1;

  text_glyph_render DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .fontControl(fontControl),
    .userSource(userSource), .user_glyph_base_address(32'h0000_1000),
    .fgColor0(fg[7:0]), .fgColor1(fg[15:8]), .fgColor2(fg[23:16]),
    .bgColor0(bg[7:0]), .bgColor1(bg[15:8]), .bgColor2(bg[23:16]),
    .codeValid(codeValid), .user_glyph_code(user_glyph_code), .codeReady(codeReady),
    .busy(busy), .romRead(romRead), .romSet(romSet), .romSize(romSize),
    .romExtended(romExtended), .romCode(romCode), .romByte(romByte), .romValid(romValid),
    .romData(romData), .memRead(memRead), .user_glyph_address(user_glyph_address),
    .memValid(memValid), .memData(memData), .pixValid(pixValid), .pixX(pixX), .pixY(pixY),
    .pixColor(pixColor), .pixReady(pixReady), .glyphDone(glyphDone));
  glyph_mem_model mem (.ref_clk(ref_clk), .lag(lag), .romRead(romRead), .romCode(romCode),
    .romByte(romByte), .memRead(memRead), .user_glyph_address(user_glyph_address),
    .romValid(romValid), .romData(romData), .memValid(memValid), .memData(memData));

  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task final_report;
    begin
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: fetch order and pixel colours
  always @(posedge ref_clk) begin
    if (romValid) curByte <= romData;
    if (memValid) curByte <= memData;
    if (memRead || romRead) begin
      if (nRead == 0)
        firstAddr = memRead ? user_glyph_address : {19'h0, romExtended, romSet, romSize, romCode};
      else if (memRead) check(user_glyph_address, prevAddr + 32'h1);
      else check({24'h0, romByte}, nRead);
      prevAddr = user_glyph_address;
      nRead = nRead + 1;
    end
    if (pixValid && pixReady) begin
      check({8'h0, pixColor}, {8'h0, (curByte[7 - pixX[2:0]] ? fg : bg)});
      nPix = nPix + 1;
    end
  end

  // One code write; valid held a second cycle, which busy must refuse
  task render(input src, input [7:0] fc, input [15:0] code, input [31:0] ea, input [31:0] ep);
    integer i;
    begin
      @(negedge ref_clk);
      stall = ~stall;
      lag = stall ? 4'h3 : 4'h1;
      userSource = src;
      fontControl = fc;
      user_glyph_code = code;
      nRead = 0;
      nPix = 0;
      codeValid = 1'b1;
      repeat (2) @(negedge ref_clk);
      codeValid = 1'b0;
      i = 0;
      while (glyphDone !== 1'b1 && i < 9000) begin
        @(negedge ref_clk);
        i = i + 1;
      end
      if (i == 9000) begin
        err_count = err_count + 1;
        final_report;
      end else begin
        check(firstAddr, ea);
        check(nPix, ep);
      end
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    render(1'b1, 8'h00, 16'h0001, 32'h0000_1010, 128);
    render(1'b1, 8'h00, 16'h7FFF, 32'h0008_0FF0, 128);
    render(1'b1, 8'h00, 16'h8001, 32'h0010_1020, 256);
    render(1'b1, 8'h10, 16'h0002, 32'h0000_1060, 288);
    render(1'b1, 8'h10, 16'h8001, 32'h0024_1048, 576);
    render(1'b1, 8'h20, 16'h0001, 32'h0000_1040, 512);
    render(1'b1, 8'h20, 16'h8002, 32'h0040_1100, 1024);
    // New colours while idle, so the two sources see different colour pairs
    fg = 24'h00FF00;
    bg = 24'h0000FF;
    render(1'b0, 8'h00, 16'h0085, 32'h0000_1085, 128);
    render(1'b0, 8'h00, 16'h00A0, 32'h0000_00A0, 128);
    render(1'b0, 8'h13, 16'h0041, 32'h0000_0D41, 288);
    render(1'b0, 8'h21, 16'h0090, 32'h0000_0690, 512);
    render(1'b0, 8'h02, 16'h809F, 32'h0000_089F, 128);
    final_report;
  end
endmodule // testbench
